// ### hdl/wheel_table_download_parser.sv
// Download record receiver and print wheel table store.
// Assumes a character receiver and transmitter on the same clock,
// the transmitter always able to take a character, and a wheel code pin.
`timescale 1ns/1ps
`default_nettype none
`include "wheel_dl_defines.svh"

// Summary of operation
// - Type one loads; types zero, nine ignored
// - Other type: NAK, exit, resident tables
// - Two-hex byte count covers remaining bytes
// - Address sent most significant byte first
// - Address outside 0040..0107 is error
// - Two bytes per entry, ascending code
// - Nibbles map high then low, twice
// - Printable flag and hammer level fields
// - Low nibble is proportional advance
// - Spoke above 99: spoke zero, no fire
// - Nonprinting entry: advance only, no print
// - Sum including checksum must be zero
// - Bad checksum: NAK, exit, resident tables
// - Reset or init clears table, picks resident
// - ESC SO DC2 enters download mode
// - ACK, then wait for S or DC4
// - Format error: NAK at once, exit
// - DC4 exits and selects downloaded table
// - Characters before S ignored
// - Only 0-9, A-F are hex; else NAK
module wheel_table_download_parser (
  input wire logic i_clock, // 125 MHz clock
  input wire logic i_arst_n, // Async reset, active low
  input wire wheel_dl_pkg::char_s i_rx, // Received character
  output wheel_dl_pkg::char_s o_tx, // Character to send
  input wire wheel_dl_pkg::bus_req_s i_bus, // Register request
  output logic [31:0] o_rdata, // Read data, one cycle later
  input wire logic [7:0] i_print_code, // Code being printed
  output wheel_dl_pkg::print_entry_s o_print, // Table entry for code
  input wire logic [7:0] i_wheel_code, // Code read from wheel
  output logic [7:0] o_wheel_sel, // Resident table selection
  output logic o_use_download, // Downloaded table selected
  output logic o_dl_mode // Download mode active
);
  import wheel_dl_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations

  parse_state_e state_r;
  byte_phase_e phase_r;
  logic nib_lo_r;
  logic [3:0] hi_nib_r;
  logic [7:0] remain_r;
  logic [7:0] sum_r;
  logic [15:0] addr_r;
  logic use_dl_r;
  logic [6:0] clr_idx_r;
  logic init_req_r;
  logic mem_we_r;
  logic [7:0] mem_wa_r;
  logic [7:0] mem_wd_r;
  logic tx_ack_r;
  logic tx_nak_r;
  logic [7:0] lookup_code_r;
  logic [7:0] ok_count_r;
  logic nak_seen_r;
  logic [7:0] mem_hi [`TBL_ENTRIES];
  logic [7:0] mem_lo [`TBL_ENTRIES];
  logic [7:0] wheel_s1_r, wheel_s2_r, wheel_s3_r, wheel_stable_r;

  logic rx_hex_ok;
  logic [3:0] rx_nib;
  logic [7:0] byte_v;
  logic [7:0] sum_nxt;
  logic [7:0] data_idx;
  logic init_wr;

  ////////////////////////////////////////////////////////////////////
  // Hex character decode

  always_comb begin
    rx_hex_ok = 1'b0;
    rx_nib = 4'h0;
    if (i_rx.data >= 8'h30 && i_rx.data <= 8'h39) begin
      rx_hex_ok = 1'b1;
      rx_nib = i_rx.data[3:0];
    end else if (i_rx.data >= 8'h41 && i_rx.data <= 8'h46) begin
      rx_hex_ok = 1'b1;
      rx_nib = i_rx.data[3:0] + 4'h9;
    end
  end

  assign byte_v = {hi_nib_r, rx_nib};
  assign sum_nxt = sum_r + byte_v;
  assign init_wr = i_bus.wr && i_bus.addr == `OFS_CTRL && i_bus.wdata[`CTRL_INIT_BIT];
  assign data_idx = 8'((addr_r - `TBL_ADDR_LO) >> 1);

  ////////////////////////////////////////////////////////////////////
  // Record parser

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_CLEAR;
      phase_r <= PH_COUNT;
      nib_lo_r <= 1'b0;
      hi_nib_r <= 4'h0;
      remain_r <= 8'h00;
      sum_r <= 8'h00;
      addr_r <= 16'h0000;
      use_dl_r <= 1'b0;
      clr_idx_r <= 7'h00;
      mem_we_r <= 1'b0;
      mem_wa_r <= 8'h00;
      mem_wd_r <= 8'h00;
      tx_ack_r <= 1'b0;
      tx_nak_r <= 1'b0;
    end else begin
      mem_we_r <= 1'b0;
      tx_ack_r <= 1'b0;
      tx_nak_r <= 1'b0;
      if (init_req_r) begin
        state_r <= ST_CLEAR;
        clr_idx_r <= 7'h00;
        use_dl_r <= 1'b0;
      end else begin
        unique case (state_r)
          ST_CLEAR: begin
            clr_idx_r <= clr_idx_r + 7'h01;
            if (clr_idx_r == `TBL_LAST) begin
              state_r <= ST_NORMAL;
            end
          end
          ST_NORMAL: begin
            if (i_rx.valid && i_rx.data == `CH_ESC) begin
              state_r <= ST_ESC1;
            end
          end
          ST_ESC1: begin
            if (i_rx.valid) begin
              if (i_rx.data == `CH_SO) begin
                state_r <= ST_ESC2;
              end else if (i_rx.data != `CH_ESC) begin
                state_r <= ST_NORMAL;
              end
            end
          end
          ST_ESC2: begin
            if (i_rx.valid) begin
              state_r <= (i_rx.data == `CH_DC2) ? ST_WAIT_S : ST_NORMAL;
            end
          end
          ST_WAIT_S: begin
            if (i_rx.valid) begin
              if (i_rx.data == `CH_START) begin
                state_r <= ST_TYPE;
              end else if (i_rx.data == `CH_DC4) begin
                state_r <= ST_NORMAL;
                use_dl_r <= 1'b1;
              end
            end
          end
          ST_TYPE: begin
            if (i_rx.valid) begin
              phase_r <= PH_COUNT;
              nib_lo_r <= 1'b0;
              sum_r <= 8'h00;
              if (i_rx.data == `CH_TYPE_TABLE) begin
                state_r <= ST_BYTES;
              end else if (i_rx.data == `CH_TYPE_HDR || i_rx.data == `CH_TYPE_EOF) begin
                state_r <= ST_WAIT_S;
              end else begin
                state_r <= ST_NORMAL;
                tx_nak_r <= 1'b1;
                use_dl_r <= 1'b0;
              end
            end
          end
          ST_BYTES: begin
            if (i_rx.valid) begin
              if (!rx_hex_ok) begin
                state_r <= ST_NORMAL;
                tx_nak_r <= 1'b1;
                use_dl_r <= 1'b0;
              end else if (!nib_lo_r) begin
                hi_nib_r <= rx_nib;
                nib_lo_r <= 1'b1;
              end else begin
                nib_lo_r <= 1'b0;
                sum_r <= sum_nxt;
                remain_r <= remain_r - 8'h01;
                unique case (phase_r)
                  PH_COUNT: begin
                    remain_r <= byte_v;
                    phase_r <= PH_ADDR_HI;
                    if (byte_v < `MIN_COUNT) begin
                      state_r <= ST_NORMAL;
                      tx_nak_r <= 1'b1;
                      use_dl_r <= 1'b0;
                    end
                  end
                  PH_ADDR_HI: begin
                    addr_r[15:8] <= byte_v;
                    phase_r <= PH_ADDR_LO;
                  end
                  PH_ADDR_LO: begin
                    addr_r[7:0] <= byte_v;
                    phase_r <= PH_DATA;
                    if ({addr_r[15:8], byte_v} < `TBL_ADDR_LO
                        || {addr_r[15:8], byte_v} > `TBL_ADDR_HI) begin
                      state_r <= ST_NORMAL;
                      tx_nak_r <= 1'b1;
                      use_dl_r <= 1'b0;
                    end
                  end
                  PH_DATA: begin
                    if (remain_r == 8'h01) begin
                      if (sum_nxt == 8'h00) begin
                        state_r <= ST_WAIT_S;
                        tx_ack_r <= 1'b1;
                      end else begin
                        state_r <= ST_NORMAL;
                        tx_nak_r <= 1'b1;
                        use_dl_r <= 1'b0;
                      end
                    end else if (addr_r > `TBL_ADDR_HI) begin
                      state_r <= ST_NORMAL;
                      tx_nak_r <= 1'b1;
                      use_dl_r <= 1'b0;
                    end else begin
                      mem_we_r <= 1'b1;
                      mem_wa_r <= {data_idx[6:0], addr_r[0]};
                      mem_wd_r <= byte_v;
                      addr_r <= addr_r + 16'h0001;
                    end
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Table memory, cleared by sweep after reset or init

  always_ff @(posedge i_clock) begin
    if (state_r == ST_CLEAR) begin
      mem_hi[clr_idx_r] <= 8'h00;
      mem_lo[clr_idx_r] <= 8'h00;
    end else if (mem_we_r) begin
      if (mem_wa_r[0]) begin
        mem_lo[mem_wa_r[7:1]] <= mem_wd_r;
      end else begin
        mem_hi[mem_wa_r[7:1]] <= mem_wd_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Entry decode for printing

  function automatic print_entry_s decode(input logic [7:0] code, input logic [7:0] b1,
                                          input logic [7:0] b2);
    print_entry_s e;
    e = '0;
    if (code >= `CODE_FIRST && code <= `CODE_LAST) begin
      e.printable = b1[7];
      e.proportional_advance = b1[3:0];
      if (b1[7]) begin
        e.hammer = b1[6:4];
        e.spoke = (b2[6:0] > `SPOKE_MAX) ? 7'h00 : b2[6:0];
        e.fire = (b2[6:0] <= `SPOKE_MAX) && (b1[6:4] != 3'h0);
      end
    end
    return e;
  endfunction : decode

  logic [6:0] print_idx;
  logic [6:0] lookup_idx;
  assign print_idx = 7'(i_print_code - `CODE_FIRST);
  assign lookup_idx = 7'(lookup_code_r - `CODE_FIRST);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_print <= '0;
    end else if (print_idx < 7'(`TBL_ENTRIES)) begin
      o_print <= decode(i_print_code, mem_hi[print_idx], mem_lo[print_idx]);
    end else begin
      o_print <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Answer characters

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx <= '0;
    end else begin
      o_tx.valid <= tx_ack_r || tx_nak_r;
      o_tx.data <= tx_nak_r ? `CH_NAK : (tx_ack_r ? `CH_ACK : 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wheel code synchroniser and resident selection

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wheel_s1_r <= 8'h00;
      wheel_s2_r <= 8'h00;
      wheel_s3_r <= 8'h00;
      wheel_stable_r <= 8'h00;
    end else begin
      wheel_s1_r <= i_wheel_code;
      wheel_s2_r <= wheel_s1_r;
      wheel_s3_r <= wheel_s2_r;
      if (wheel_s2_r == wheel_s3_r) begin
        wheel_stable_r <= wheel_s3_r;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wheel_sel <= 8'h00;
      o_use_download <= 1'b0;
      o_dl_mode <= 1'b0;
    end else begin
      if (state_r == ST_CLEAR) begin
        o_wheel_sel <= wheel_stable_r;
      end
      o_use_download <= use_dl_r;
      o_dl_mode <= (state_r == ST_WAIT_S) || (state_r == ST_TYPE) || (state_r == ST_BYTES);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register slave

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      init_req_r <= 1'b0;
      lookup_code_r <= `LOOKUP_RST;
    end else begin
      init_req_r <= init_wr;
      if (i_bus.wr && i_bus.addr == `OFS_LOOKUP) begin
        lookup_code_r <= i_bus.wdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ok_count_r <= 8'h00;
      nak_seen_r <= 1'b0;
    end else begin
      if (tx_ack_r) begin
        ok_count_r <= ok_count_r + 8'h01;
      end
      if (tx_nak_r) begin
        nak_seen_r <= 1'b1;
      end else if (i_bus.wr && i_bus.addr == `OFS_STATUS && i_bus.wdata[2]) begin
        nak_seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        `OFS_STATUS: o_rdata <= {16'h0000, ok_count_r, 4'h0, state_r == ST_CLEAR,
                                 nak_seen_r, use_dl_r, o_dl_mode};
        `OFS_LOOKUP: o_rdata <= {24'h000000, lookup_code_r};
        `OFS_ENTRY: o_rdata <= (lookup_idx < 7'(`TBL_ENTRIES))
                               ? {16'h0000, mem_hi[lookup_idx], mem_lo[lookup_idx]}
                               : 32'h00000000;
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule : wheel_table_download_parser
`default_nettype wire

// ### hdl/wheel_dl_defines.svh
// Constants for the print wheel table download parser.
// Assumes inclusion by bare name from the parser module and the bench files.
`ifndef WHEEL_DL_DEFINES_SVH
`define WHEEL_DL_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_LOOKUP 8'h08
`define OFS_ENTRY 8'h0c
`define CTRL_INIT_BIT 0
`define LOOKUP_RST 8'h20

// Characters
`define CH_ESC 8'h1b
`define CH_SO 8'h0e
`define CH_DC2 8'h12
`define CH_DC4 8'h14
`define CH_ACK 8'h06
`define CH_NAK 8'h15
`define CH_START 8'h53
`define CH_TYPE_TABLE 8'h31
`define CH_TYPE_HDR 8'h30
`define CH_TYPE_EOF 8'h39

// Table layout
`define TBL_ADDR_LO 16'h0040
`define TBL_ADDR_HI 16'h0107
`define TBL_ENTRIES 100
`define TBL_LAST 7'h63
`define CODE_FIRST 8'h20
`define CODE_LAST 8'h83
`define SPOKE_MAX 7'h63
`define MIN_COUNT 8'h03

`endif

// ### hdl/wheel_dl_pkg.sv
// Types shared by the print wheel table download parser.
// Assumes the defines header is on the include path.
package wheel_dl_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } char_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic printable;
    logic fire;
    logic [2:0] hammer;
    logic [3:0] proportional_advance;
    logic [6:0] spoke;
  } print_entry_s;

  typedef enum logic [6:0] {
    ST_NORMAL = 7'b0000001,
    ST_ESC1 = 7'b0000010,
    ST_ESC2 = 7'b0000100,
    ST_WAIT_S = 7'b0001000,
    ST_TYPE = 7'b0010000,
    ST_BYTES = 7'b0100000,
    ST_CLEAR = 7'b1000000
  } parse_state_e;

  typedef enum logic [1:0] {
    PH_COUNT = 2'h0,
    PH_ADDR_HI = 2'h1,
    PH_ADDR_LO = 2'h2,
    PH_DATA = 2'h3
  } byte_phase_e;

endpackage : wheel_dl_pkg

// ### tb/wheel_dl_asserts.sv
// Checker of the parser's answers, mode flags and table outputs.
// Assumes it is bound onto the parser top module.
`timescale 1ns/1ps
`default_nettype none
`include "wheel_dl_defines.svh"
module wheel_dl_asserts (
  input wire logic i_clock, // Clock
  input wire logic i_arst_n, // Reset, active low
  input wire wheel_dl_pkg::char_s i_rx, // Received character
  input wire wheel_dl_pkg::char_s o_tx, // Answer character
  input wire wheel_dl_pkg::print_entry_s o_print, // Table entry
  input wire logic o_use_download, // Download table in use
  input wire logic o_dl_mode // Download mode
);
  import wheel_dl_pkg::*;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);
  //////////////////////////////////////////
  property p_tx_code;
    o_tx.valid |-> o_tx.data == `CH_ACK || o_tx.data == `CH_NAK;
  endproperty
  a_tx_code: assert property (p_tx_code)
    else $error("answer code not ACK or NAK");
  property p_tx_in_mode;
    o_tx.valid |-> $past(o_dl_mode, 2);
  endproperty
  a_tx_in_mode: assert property (p_tx_in_mode)
    else $error("answer outside a record");
  property p_nak_exit;
    o_tx.valid && o_tx.data == `CH_NAK |-> ##[0:1] (!o_dl_mode && !o_use_download);
  endproperty
  a_nak_exit: assert property (p_nak_exit)
    else $error("mode kept after NAK");
  property p_ack_stay;
    o_tx.valid && o_tx.data == `CH_ACK |-> o_dl_mode;
  endproperty
  a_ack_stay: assert property (p_ack_stay)
    else $error("mode left after ACK");
  property p_enter;
    i_rx.valid && i_rx.data == `CH_ESC ##[1:3] i_rx.valid && i_rx.data == `CH_SO
      ##[1:3] i_rx.valid && i_rx.data == `CH_DC2 |-> ##2 o_dl_mode;
  endproperty
  a_enter: assert property (p_enter)
    else $error("entry sequence not taken");
  property p_dc4;
    i_rx.valid && i_rx.data == `CH_DC4 && o_dl_mode |-> ##[1:2] !o_dl_mode;
  endproperty
  a_dc4: assert property (p_dc4)
    else $error("DC4 did not end mode");
  property p_spoke;
    o_print.spoke <= `SPOKE_MAX;
  endproperty
  a_spoke: assert property (p_spoke)
    else $error("spoke above limit");
  property p_fire;
    o_print.fire |-> o_print.printable && o_print.hammer != 3'h0;
  endproperty
  a_fire: assert property (p_fire)
    else $error("fire without printable energy");
  property p_nonprint;
    !o_print.printable |-> !o_print.fire && o_print.hammer == 3'h0 && o_print.spoke == 7'h00;
  endproperty
  a_nonprint: assert property (p_nonprint)
    else $error("nonprinting entry not advance only");
endmodule : wheel_dl_asserts
bind wheel_table_download_parser wheel_dl_asserts u_chk (
  .i_clock(i_clock),
  .i_arst_n(i_arst_n),
  .i_rx(i_rx),
  .o_tx(o_tx),
  .o_print(o_print),
  .o_use_download(o_use_download),
  .o_dl_mode(o_dl_mode)
);
`default_nettype wire

// ### tb/wheel_host_model.sv
// Host model: sends download records as ASCII hex characters.
// Assumes one character per valid pulse, a spare cycle between.
`timescale 1ns/1ps
`default_nettype none
`include "wheel_dl_defines.svh"
module wheel_host_model (
  input wire logic i_clock, // Bench clock
  output wheel_dl_pkg::char_s o_rx // Character to device
);
  import wheel_dl_pkg::*;
  //////////////////////////////////////////
  initial o_rx = '0;
  function automatic logic [7:0] b1(input int k);
    return {k[0], 3'(k % 5), 4'(k)};
  endfunction : b1
  function automatic logic [7:0] b2(input int k, input int off);
    return {1'b0, 7'(k + off)};
  endfunction : b2
  function automatic logic [7:0] hx(input logic [3:0] n);
    return n < 4'ha ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx
  task automatic send(input logic [7:0] c);
    @(posedge i_clock) o_rx <= '{1'b1, c};
    @(posedge i_clock) o_rx <= '{1'b0, ~c};
  endtask : send
  task automatic hexb(input logic [7:0] b, inout logic [7:0] s);
    s = s + b;
    send(hx(b[7:4]));
    send(hx(b[3:0]));
  endtask : hexb
  task automatic rec(input logic [7:0] typ, input logic [15:0] adr, input int n,
                     input int off, input logic bad);
    logic [7:0] s;
    int k0;
    s = 8'h00;
    k0 = int'(adr) / 2 - 32;
    send(`CH_START);
    send(typ);
    hexb(8'(3 + 2 * n), s);
    hexb(adr[15:8], s);
    hexb(adr[7:0], s);
    for (int i = 0; i < n; i++) begin
      hexb(b1(k0 + i), s);
      hexb(b2(k0 + i, off), s);
    end
    hexb((8'h00 - s) ^ {7'h00, bad}, s);
  endtask : rec
endmodule : wheel_host_model
`default_nettype wire

// ### tb/wheel_table_download_parser_tb.sv
// Bench for the download parser: record rows, then full load checks.
// Assumes the host model drives the character input.
`timescale 1ns/1ps
`default_nettype none
`include "wheel_dl_defines.svh"
module wheel_table_download_parser_tb;
  import wheel_dl_pkg::*;
  typedef struct packed {
    logic [7:0] typ;
    logic [15:0] adr;
    logic bad;
    logic [7:0] tx;
    logic mode;
  } row_s;
  logic i_clock, i_arst_n, use_dl, mode;
  char_s rx, tx;
  bus_req_s bus;
  logic [31:0] rdata, d;
  logic [7:0] pcode, wsel, last_tx, wcode;
  print_entry_s pr;
  int num_errors, checks;
  row_s rows [8] = '{'{8'h31, 16'h0040, 1'b0, 8'h06, 1'b1}, '{8'h30, 16'h0040, 1'b0, 8'h00, 1'b1},
    '{8'h39, 16'h0040, 1'b0, 8'h00, 1'b1}, '{8'h32, 16'h0040, 1'b0, 8'h15, 1'b0},
    '{8'h31, 16'h003e, 1'b0, 8'h15, 1'b0}, '{8'h31, 16'h0108, 1'b0, 8'h15, 1'b0},
    '{8'h31, 16'h0106, 1'b0, 8'h06, 1'b1}, '{8'h31, 16'h0040, 1'b1, 8'h15, 1'b0}};
  //////////////////////////////////////////
  wheel_host_model host (.i_clock(i_clock), .o_rx(rx));
  wheel_table_download_parser dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_rx(rx),
    .o_tx(tx), .i_bus(bus), .o_rdata(rdata), .i_print_code(pcode), .o_print(pr),
    .i_wheel_code(wcode), .o_wheel_sel(wsel), .o_use_download(use_dl), .o_dl_mode(mode));
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  always @(negedge i_clock) if (tx.valid === 1'b1) last_tx = tx.data;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock) bus <= '{1'b1, 1'b0, a, v};
    @(posedge i_clock) bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock) bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge i_clock) bus <= '0;
    #1 v = rdata;
  endtask : rd
  task automatic ent(input logic [7:0] c, input logic [31:0] exp);
    wr(`OFS_LOOKUP, 32'(c));
    rd(`OFS_ENTRY, d);
    chk("entry", d, exp);
  endtask : ent
  task automatic enter();
    last_tx = 8'h00;
    host.send(`CH_ESC);
    host.send(`CH_SO);
    host.send(`CH_DC2);
  endtask : enter
  function automatic logic [15:0] exp_pr(input int c);
    int k;
    logic f;
    k = c - 32;
    f = k + 1 <= 99 && k % 5 != 0;
    if (c > 131) return 16'h0000;
    if (k % 2 == 0) return {5'h00, 4'(k), 7'h00};
    return {1'b1, f, 3'(k % 5), 4'(k), k + 1 <= 99 ? 7'(k + 1) : 7'h00};
  endfunction : exp_pr
  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    complete_run();
  end
  initial begin
    num_errors = 0;
    checks = 0;
    i_arst_n = 1'b0;
    bus = '0;
    pcode = 8'h20;
    wcode = 8'h5a;
    repeat (16) @(posedge i_clock);
    chk("idle", 32'({mode, use_dl}), 32'h0);
    i_arst_n <= 1'b1;
    repeat (110) @(posedge i_clock);
    ent(8'h20, 32'h0);
    chk("wheel_sel", 32'(wsel), 32'h5a);
    foreach (rows[i]) begin
      enter();
      host.send(8'h0d);
      host.rec(rows[i].typ, rows[i].adr, 1, 0, rows[i].bad);
      repeat (6) @(posedge i_clock);
      #1 chk("tx", 32'(last_tx), 32'(rows[i].tx));
      chk("mode", 32'(mode), 32'(rows[i].mode));
    end
    enter();
    host.rec(8'h31, 16'h0040, 100, 1, 1'b0);
    repeat (6) @(posedge i_clock);
    #1 chk("tx", 32'(last_tx), 32'(`CH_ACK));
    host.send(`CH_DC4);
    repeat (3) @(posedge i_clock);
    #1 chk("use_download", 32'(use_dl), 32'h1);
    rd(`OFS_STATUS, d);
    chk("status", d & 32'hff0f, 32'h0306);
    for (int c = 32; c <= 132; c++) begin
      @(posedge i_clock) pcode <= 8'(c);
      @(posedge i_clock);
      #1 chk("print", 32'(pr), 32'(exp_pr(c)));
    end
    ent(8'h21, {16'h0, host.b1(1), host.b2(1, 1)});
    ent(8'h83, {16'h0, host.b1(99), host.b2(99, 1)});
    rd(8'h10, d);
    chk("unmapped", d, 32'h0);
    wcode <= 8'h3c;
    wr(`OFS_CTRL, 32'h1);
    repeat (110) @(posedge i_clock);
    #1 chk("use_download", 32'(use_dl), 32'h0);
    chk("wheel_sel", 32'(wsel), 32'h3c);
    ent(8'h21, 32'h0);
    enter();
    host.send(`CH_START);
    host.send(`CH_TYPE_TABLE);
    host.send(8'h47);
    repeat (4) @(posedge i_clock);
    #1 chk("tx", 32'(last_tx), 32'(`CH_NAK));
    chk("mode", 32'(mode), 32'h0);
    enter();
    host.rec(8'h31, 16'h0106, 2, 0, 1'b0);
    repeat (4) @(posedge i_clock);
    #1 chk("tx", 32'(last_tx), 32'(`CH_NAK));
    chk("mode", 32'(mode), 32'h0);
    enter();
    host.send(`CH_START);
    host.send(`CH_TYPE_TABLE);
    host.send(8'h30);
    host.send(8'h32);
    repeat (4) @(posedge i_clock);
    #1 chk("tx", 32'(last_tx), 32'(`CH_NAK));
    chk("mode", 32'(mode), 32'h0);
    complete_run();
  end
endmodule : wheel_table_download_parser_tb
`default_nettype wire
